// [pkg/pcsr_consts.svh]
// constants of the configuration status and class code register block
`ifndef PCSR_CONSTS_SVH
`define PCSR_CONSTS_SVH

// byte offsets in configuration space
`define PCSR_OFS_COMMAND        8'h04
`define PCSR_OFS_STATUS         8'h06
`define PCSR_OFS_CLASS          8'h08

// command register bits kept here
`define PCSR_CMD_PARITY_BIT     6
`define PCSR_CMD_SERR_BIT       8

// status register bit positions
`define PCSR_ST_POISON_BIT        15
`define PCSR_ST_SYSTEM_ERROR_BIT  14
`define PCSR_ST_MASTER_ABORT_BIT  13
`define PCSR_ST_TABORT_RX_BIT     12
`define PCSR_ST_TABORT_TX_BIT     11
`define PCSR_ST_DATA_PARITY_BIT   8
`define PCSR_ST_CHAIN_BIT         4
`define PCSR_ST_INT_BIT           3

// reset values
`define PCSR_CMD_RESET          16'h0000
`define PCSR_FLAGS_RESET        6'h00

// class code fields
`define PCSR_BASE_CLASS         8'h0C
`define PCSR_SUB_CLASS          8'h03
`define PCSR_PROG_IF            8'h30

`endif

// [pkg/pcsr_pkg.sv]
// types of the configuration status and class code register block
package pcsr_pkg;

    // one configuration access, byte address of the dword plus lanes
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcsr_cfg_req_s;

    // one-cycle link events from the transaction layer
    typedef struct packed {
        logic poisoned_tlp_rx;
        logic err_msg_tx;
        logic cpl_ur_rx;
        logic cpl_ca_rx;
        logic cpl_ca_tx;
        logic poisoned_cpl_rx;
        logic poisoned_wr_rx;
    } pcsr_event_s;

    // latched error flags in status register order
    typedef struct packed {
        logic detected_poison_flag;
        logic signaled_system_error_flag;
        logic received_master_abort_flag;
        logic received_target_abort_flag;
        logic signaled_target_abort_flag;
        logic master_data_parity_flag;
    } pcsr_flags_s;

    typedef enum logic [1:0] {
        PCSR_SEL_NONE,
        PCSR_SEL_CMD_STATUS,
        PCSR_SEL_CLASS
    } pcsr_sel_e;

endpackage

// [verilog/pcsr_flag_bank.sv]
// sticky error flags, set by hardware, cleared by writing one
`timescale 1ns/1ps
`include "pcsr_consts.svh"

module pcsr_flag_bank #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // events and clears
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clr_vec,
    // state
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags;

    // set wins over a clear in the same cycle so no event is lost
    assign next_flags = (flags & ~clr_vec) | set_vec;

    always_ff @(posedge clk) begin
        if (srst) begin
            flags <= WIDTH'(`PCSR_FLAGS_RESET);
        end else begin
            flags <= next_flags;
        end
    end

endmodule

// [verilog/pcsr_rd_stage.sv]
// registered read answer for configuration reads
`timescale 1ns/1ps

module pcsr_rd_stage #(
    parameter int DW = 32
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          srst,
    // selected word
    input  wire logic          rd,
    input  wire logic [DW-1:0] word,
    // answer
    output logic               rd_valid,
    output logic      [DW-1:0] rd_data
);

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_valid <= rd;
            rd_data  <= rd ? word : rd_data;
        end
    end

endmodule

// [verilog/pcsr_top.sv]
// status and class code configuration registers of the host controller function
`timescale 1ns/1ps
`include "pcsr_consts.svh"

module pcsr_top #(
    // arbitrary neutral silicon revision value
    parameter logic [7:0] REVISION = 8'h5A
) (
    // clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  SRST,
    // configuration access
    input  wire pcsr_pkg::pcsr_cfg_req_s CFG_REQ,
    output logic                       CFG_RD_VALID,
    output logic [31:0]                CFG_RD_DATA,
    output logic                       CFG_WR_DONE,
    // link events
    input  wire pcsr_pkg::pcsr_event_s EVENTS,
    // function state
    input  wire logic                  INT_PENDING,
    // enables to the transaction layer
    output logic                       PARITY_RESPONSE_ENABLE,
    output logic                       SYSTEM_ERROR_REPORT_ENABLE,
    output logic                       ERR_MSG_PERMIT,
    // flag view
    output pcsr_pkg::pcsr_flags_s      FLAGS
);

    localparam int NFLAGS = 6;

    // dword decode
    function automatic pcsr_pkg::pcsr_sel_e decode(input logic [7:0] addr);
        logic [7:0] dw;
        dw = {addr[7:2], 2'b00};
        if (dw == `PCSR_OFS_COMMAND) begin
            decode = pcsr_pkg::PCSR_SEL_CMD_STATUS;
        end else if (dw == `PCSR_OFS_CLASS) begin
            decode = pcsr_pkg::PCSR_SEL_CLASS;
        end else begin
            decode = pcsr_pkg::PCSR_SEL_NONE;
        end
    endfunction

    pcsr_pkg::pcsr_sel_e  sel;
    logic                 wr_cmd_lo;
    logic                 wr_cmd_hi;
    logic                 wr_status_lo;
    logic                 wr_status_hi;
    logic [15:0]          command;
    logic [15:0]          next_command;
    logic [15:0]          status_word;
    logic [31:0]          class_word;
    logic [31:0]          cmd_status_word;
    logic [31:0]          rd_word;
    logic [NFLAGS-1:0]    set_vec;
    logic [NFLAGS-1:0]    clr_vec;
    logic [NFLAGS-1:0]    flags;
    logic [15:0]          clr_mask;
    logic                 parity_en;
    logic                 serr_en;
    logic                 wr_done;

    assign sel = decode(CFG_REQ.addr);

    // byte lane write strobes of the command/status dword
    assign wr_cmd_lo    = CFG_REQ.wr && (sel == pcsr_pkg::PCSR_SEL_CMD_STATUS) && CFG_REQ.be[0];
    assign wr_cmd_hi    = CFG_REQ.wr && (sel == pcsr_pkg::PCSR_SEL_CMD_STATUS) && CFG_REQ.be[1];
    assign wr_status_lo = CFG_REQ.wr && (sel == pcsr_pkg::PCSR_SEL_CMD_STATUS) && CFG_REQ.be[2];
    assign wr_status_hi = CFG_REQ.wr && (sel == pcsr_pkg::PCSR_SEL_CMD_STATUS) && CFG_REQ.be[3];

    // only the two enables live here; the rest of the command word belongs elsewhere
    assign next_command[`PCSR_CMD_PARITY_BIT] = wr_cmd_lo ? CFG_REQ.wdata[`PCSR_CMD_PARITY_BIT]
                                                          : command[`PCSR_CMD_PARITY_BIT];
    assign next_command[`PCSR_CMD_SERR_BIT]   = wr_cmd_hi ? CFG_REQ.wdata[`PCSR_CMD_SERR_BIT]
                                                          : command[`PCSR_CMD_SERR_BIT];
    assign next_command[15:9] = 7'h00;
    assign next_command[7]    = 1'b0;
    assign next_command[5:0]  = 6'h00;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            command <= `PCSR_CMD_RESET;
        end else begin
            command <= next_command;
        end
    end

    assign parity_en = command[`PCSR_CMD_PARITY_BIT];
    assign serr_en   = command[`PCSR_CMD_SERR_BIT];

    // error messages held back while reporting is disabled
    assign ERR_MSG_PERMIT = serr_en;

    // hardware set terms, in flag order
    assign set_vec[5] = EVENTS.poisoned_tlp_rx;
    assign set_vec[4] = EVENTS.err_msg_tx && serr_en;
    assign set_vec[3] = EVENTS.cpl_ur_rx;
    assign set_vec[2] = EVENTS.cpl_ca_rx;
    assign set_vec[1] = EVENTS.cpl_ca_tx;
    assign set_vec[0] = parity_en && (EVENTS.poisoned_cpl_rx || EVENTS.poisoned_wr_rx);

    // write one to clear, lane by lane; status sits in bytes 2 and 3
    assign clr_mask = {wr_status_hi ? CFG_REQ.wdata[31:24] : 8'h00,
                       wr_status_lo ? CFG_REQ.wdata[23:16] : 8'h00};
    assign clr_vec  = {clr_mask[`PCSR_ST_POISON_BIT],
                       clr_mask[`PCSR_ST_SYSTEM_ERROR_BIT],
                       clr_mask[`PCSR_ST_MASTER_ABORT_BIT],
                       clr_mask[`PCSR_ST_TABORT_RX_BIT],
                       clr_mask[`PCSR_ST_TABORT_TX_BIT],
                       clr_mask[`PCSR_ST_DATA_PARITY_BIT]};

    pcsr_flag_bank #(
        .WIDTH   (NFLAGS)
    ) u_flags (
        .clk     (SYS_CLK),
        .srst    (SRST),
        .set_vec (set_vec),
        .clr_vec (clr_vec),
        .flags   (flags)
    );

    // status word assembly; unlisted bits are hardwired zero
    always_comb begin
        status_word                            = 16'h0000;
        status_word[`PCSR_ST_POISON_BIT]       = flags[5];
        status_word[`PCSR_ST_SYSTEM_ERROR_BIT] = flags[4];
        status_word[`PCSR_ST_MASTER_ABORT_BIT] = flags[3];
        status_word[`PCSR_ST_TABORT_RX_BIT]    = flags[2];
        status_word[`PCSR_ST_TABORT_TX_BIT]    = flags[1];
        status_word[`PCSR_ST_DATA_PARITY_BIT]  = flags[0];
        status_word[`PCSR_ST_CHAIN_BIT]        = 1'b1;
        status_word[`PCSR_ST_INT_BIT]          = INT_PENDING;
    end

    // constant word, no write path reaches it
    assign class_word = {`PCSR_BASE_CLASS, `PCSR_SUB_CLASS, `PCSR_PROG_IF, REVISION};

    assign cmd_status_word = {status_word, command};

    // unmapped dwords answer zero
    always_comb begin
        case (sel)
            pcsr_pkg::PCSR_SEL_CMD_STATUS: rd_word = cmd_status_word;
            pcsr_pkg::PCSR_SEL_CLASS:      rd_word = class_word;
            default:                       rd_word = 32'h00000000;
        endcase
    end

    pcsr_rd_stage #(
        .DW       (32)
    ) u_rd (
        .clk      (SYS_CLK),
        .srst     (SRST),
        .rd       (CFG_REQ.rd),
        .word     (rd_word),
        .rd_valid (CFG_RD_VALID),
        .rd_data  (CFG_RD_DATA)
    );

    // every write is acknowledged, including ignored ones
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            wr_done <= 1'b0;
        end else begin
            wr_done <= CFG_REQ.wr;
        end
    end

    assign CFG_WR_DONE                = wr_done;
    assign PARITY_RESPONSE_ENABLE     = parity_en;
    assign SYSTEM_ERROR_REPORT_ENABLE = serr_en;
    assign FLAGS                      = pcsr_pkg::pcsr_flags_s'(flags);

endmodule

// [verif/pcsr_top_asserts.sv]
// concurrent checks on the status and class code register ports
`timescale 1ns/1ps
module pcsr_top_asserts #(
    parameter logic [7:0] REVISION = 8'h5A
) (
    // clock and reset
    input wire logic                    SYS_CLK,
    input wire logic                    SRST,
    // configuration access
    input wire pcsr_pkg::pcsr_cfg_req_s CFG_REQ,
    input wire logic                    CFG_RD_VALID,
    input wire logic [31:0]             CFG_RD_DATA,
    input wire logic                    CFG_WR_DONE,
    // events and state
    input wire pcsr_pkg::pcsr_event_s   EVENTS,
    input wire logic                    INT_PENDING,
    input wire logic                    PARITY_RESPONSE_ENABLE,
    input wire logic                    SYSTEM_ERROR_REPORT_ENABLE,
    input wire logic                    ERR_MSG_PERMIT,
    input wire pcsr_pkg::pcsr_flags_s   FLAGS
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);
    wire st_rd = CFG_REQ.rd && CFG_REQ.addr[7:2] == 6'h01;
    wire cl_rd = CFG_REQ.rd && CFG_REQ.addr[7:2] == 6'h02;
    wire cs_wr = CFG_REQ.wr && CFG_REQ.addr[7:2] == 6'h01;

    AST_POISON: assert property (EVENTS.poisoned_tlp_rx |=> FLAGS.detected_poison_flag)
        else $error("poison flag missed");
    AST_SYSTEM_ERROR: assert property (EVENTS.err_msg_tx && !CFG_REQ.wr |=>
        FLAGS.signaled_system_error_flag ==
        ($past(SYSTEM_ERROR_REPORT_ENABLE) || $past(FLAGS.signaled_system_error_flag)))
        else $error("system error flag wrong");
    AST_MASTER_ABORT: assert property (EVENTS.cpl_ur_rx |=> FLAGS.received_master_abort_flag)
        else $error("master abort flag missed");
    AST_TABORT_RX: assert property (EVENTS.cpl_ca_rx |=> FLAGS.received_target_abort_flag)
        else $error("received abort flag missed");
    AST_TABORT_TX: assert property (EVENTS.cpl_ca_tx |=> FLAGS.signaled_target_abort_flag)
        else $error("signaled abort flag missed");
    AST_DATA_PARITY: assert property ((EVENTS.poisoned_cpl_rx || EVENTS.poisoned_wr_rx) && !CFG_REQ.wr |=>
        FLAGS.master_data_parity_flag == ($past(PARITY_RESPONSE_ENABLE) || $past(FLAGS.master_data_parity_flag)))
        else $error("data parity flag wrong");
    AST_STATUS_RD: assert property (st_rd |=> CFG_RD_VALID && CFG_RD_DATA[26:25] == 2'h0 &&
        CFG_RD_DATA[23:16] == {4'h1, $past(INT_PENDING), 3'h0})
        else $error("status fixed bits wrong");
    AST_CLASS_RD: assert property (cl_rd |=> CFG_RD_VALID &&
        CFG_RD_DATA == {24'h0C0330, REVISION})
        else $error("class word wrong");
    AST_STICKY: assert property (!CFG_REQ.wr |=> (FLAGS & $past(FLAGS)) == $past(FLAGS))
        else $error("flag dropped without clear");
    AST_SERR_RESET: assert property ($fell(SRST) |-> !SYSTEM_ERROR_REPORT_ENABLE && !ERR_MSG_PERMIT)
        else $error("error reporting enabled out of reset");
    AST_PERMIT: assert property (ERR_MSG_PERMIT == SYSTEM_ERROR_REPORT_ENABLE)
        else $error("message permit differs from enable");
    AST_SERR_WR: assert property (cs_wr && CFG_REQ.be[1] |=>
        SYSTEM_ERROR_REPORT_ENABLE == $past(CFG_REQ.wdata[8]))
        else $error("reporting enable not written");
    AST_PARITY_WR: assert property (cs_wr && CFG_REQ.be[0] |=>
        PARITY_RESPONSE_ENABLE == $past(CFG_REQ.wdata[6]))
        else $error("parity enable not written");
    AST_CLEAR: assert property (cs_wr && CFG_REQ.be[3] && CFG_REQ.wdata[29] && !EVENTS.cpl_ur_rx |=>
        !FLAGS.received_master_abort_flag)
        else $error("flag not cleared by one");
    AST_WR_DONE: assert property (CFG_WR_DONE == $past(CFG_REQ.wr))
        else $error("write answer wrong");
endmodule

bind pcsr_top pcsr_top_asserts #(.REVISION(REVISION)) u_pcsr_top_asserts (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .CFG_REQ(CFG_REQ), .CFG_RD_VALID(CFG_RD_VALID),
    .CFG_RD_DATA(CFG_RD_DATA), .CFG_WR_DONE(CFG_WR_DONE), .EVENTS(EVENTS), .INT_PENDING(INT_PENDING),
    .PARITY_RESPONSE_ENABLE(PARITY_RESPONSE_ENABLE), .SYSTEM_ERROR_REPORT_ENABLE(SYSTEM_ERROR_REPORT_ENABLE),
    .ERR_MSG_PERMIT(ERR_MSG_PERMIT), .FLAGS(FLAGS));

// [verif/pcsr_rc_model.sv]
// root complex model issuing configuration reads and writes
`timescale 1ns/1ps
module pcsr_rc_model (
    // clock
    input  wire logic               clk,
    // configuration access
    output pcsr_pkg::pcsr_cfg_req_s req,
    input  wire logic               rd_valid,
    input  wire logic [31:0]        rd_data,
    input  wire logic               wr_done
);
    initial req = '0;
    // idle lanes carry the inverse of the last access, so stale values never match
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic ok, output logic [31:0] q);
        @(posedge clk);
        #1 req = {~w, w, a, be, d};
        @(posedge clk);
        #1 req = {1'h0, 1'h0, ~a, ~be, ~d};
        ok = w ? wr_done : rd_valid;
        q = rd_data;
    endtask
endmodule

// [verif/tb_top.sv]
// self-checking bench of the status and class code registers
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] REV = 8'hA7;
    logic                    sys_clk = 1'h0;
    logic                    srst = 1'h1;
    logic                    int_pending = 1'h0;
    pcsr_pkg::pcsr_cfg_req_s cfg_req;
    pcsr_pkg::pcsr_event_s   events = '0;
    pcsr_pkg::pcsr_flags_s   flags;
    logic                    rd_valid, wr_done, par_en, serr_en, permit, ok;
    logic [31:0]             rd_data, q;
    logic [5:0]              fl [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h01};
    int                      errors = 0;
    int                      compares = 0;

    always #12.5 sys_clk = ~sys_clk;

    pcsr_top #(.REVISION(REV)) u_pcsr_top (
        .SYS_CLK(sys_clk), .SRST(srst), .CFG_REQ(cfg_req), .CFG_RD_VALID(rd_valid),
        .CFG_RD_DATA(rd_data), .CFG_WR_DONE(wr_done), .EVENTS(events), .INT_PENDING(int_pending),
        .PARITY_RESPONSE_ENABLE(par_en), .SYSTEM_ERROR_REPORT_ENABLE(serr_en),
        .ERR_MSG_PERMIT(permit), .FLAGS(flags));
    pcsr_rc_model rc (.clk(sys_clk), .req(cfg_req), .rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done));

    task automatic report_and_stop;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rc.access(1'h0, a, 4'hF, 32'h0, ok, q);
        chk({31'h0, ok}, 32'h1);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        rc.access(1'h1, a, be, d, ok, q);
        chk({31'h0, ok}, 32'h1);
    endtask
    // events last exactly one cycle, as the transaction layer pulses them
    task automatic ev(input logic [6:0] e);
        @(posedge sys_clk);
        #1 events = pcsr_pkg::pcsr_event_s'(e);
        @(posedge sys_clk);
        #1 events = '0;
    endtask

    initial begin
        #50000;
        errors++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        #1 srst = 1'h0;
        chk({30'h0, serr_en, permit}, 32'h0);
        rd(8'h04, 32'h0010_0000);
        int_pending = 1'h1;
        rd(8'h06, 32'h0018_0000);
        rd(8'h08, {24'h0C0330, REV});
        wr(8'h08, 4'hF, 32'hFFFF_FFFF);
        rd(8'h08, {24'h0C0330, REV});
        rd(8'h40, 32'h0);
        // both enables still off: only the unconditional flags may latch
        ev(7'h7F);
        chk({26'h0, flags}, 32'h2E);
        wr(8'h04, 4'hC, 32'h0);
        chk({26'h0, flags}, 32'h2E);
        wr(8'h04, 4'hF, 32'hFFFF_0140);
        chk({26'h0, flags}, 32'h0);
        chk({30'h0, par_en, serr_en}, 32'h3);
        for (int i = 0; i < 7; i++) begin
            ev(7'h40 >> i);
            chk({26'h0, flags}, {26'h0, fl[i]});
            rd(8'h04, {fl[i][5:1], 2'h0, fl[i][0], 8'h18, 16'h0140});
            wr(8'h04, 4'hC, 32'hFFFF_0000);
            chk({26'h0, flags}, 32'h0);
        end
        report_and_stop;
    end
endmodule
